// file: shared/adc_seq_defs.vh
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH
`define CAL_DEMAND_BIT      7
`define MODE_HI             6
`define MODE_LO             5
`define SCAN_HI             4
`define SCAN_LO             3
`define SNAP_HI             2
`define SNAP_LO             0
`define CONTROL_A_RESET     8'h00
`define MODE_SCAN           2'h0
`define MODE_SNAPSHOT       2'h1
`define MODE_SINGLE         2'h2
`define MODE_SHUTDOWN       2'h3
`define SNAP_SENSE_PAIR     3'h6
`define SNAP_GPIO_PAIR      3'h7
`define ALERT_FOUR_SNAP_HI  7
`define ALERT_FOUR_SNAP_LO  6
`define CH_SENSE_ONE        3'h0
`define CH_SENSE_TWO        3'h1
`define CH_GPIO_ONE         3'h2
`define CH_GPIO_FOUR        3'h5
`define STAT_I1             0
`define STAT_I2             1
`define STAT_PWR_ONE        2
`define STAT_PWR_TWO        3
`define STAT_V_LO           4
`endif

// file: src/adc_conversion_sequencer.v
`timescale 1ns/1ps
`include "adc_seq_defs.vh"
// Summary of operation
// - Control bit 7 low calibrates before every current conversion; high calibrates on demand.
// - Mode 00 runs continuous scan repeatedly without host action; it is reset default.
// - Mode 01 snapshot starts all converters together; voltage converts selected channel(s), stops.
// - In snapshot each current converter converts exactly once then stops.
// - Scan select picks all six, sense pair, gpio 1-2, or gpio 1-4 inputs.
// - Snapshot codes 0-5 convert one voltage; currents measured, power not updated.
// - Snapshot codes 6 and 7 convert a pair and update power results.
// - Snapshot completion halts converters and sets matching new-data status bits.
// - Snapshot alert enable bits raise an alert when a snapshot finishes.
// - Host rewrites control to request another snapshot; each write starts one.
// - Mode 10 measures all six voltages once, updates results, then halts.
// - During bus traffic result register updates are blocked and those results lost.
// - Mode 11 shuts converters and reference down, registers stay accessible.
// - Demand calibration runs once right after each control write that does not select shutdown (mode 11).
module adc_conversion_sequencer
(
   input  wire       i_clk_sys,
   input  wire       i_rst,
   input  wire       i_ce,
   input  wire       i_ctrl_wr,
   input  wire [7:0] i_ctrl_wdata,
   input  wire [1:0] i_alert_enable_four,
   input  wire       i_bus_busy,
   input  wire       i_iconv_done,
   input  wire       i_vconv_done,
   output reg  [7:0] o_adc_control_a,
   output reg        o_iconv_start,
   output reg        o_iconv_cal,
   output reg        o_vconv_start,
   output reg  [2:0] o_vconv_chan,
   output reg        o_power_update,
   output reg        o_current_update,
   output reg        o_voltage_update,
   output reg  [2:0] o_voltage_chan,
   output reg  [9:0] o_status_set,
   output reg        o_alert,
   output reg        o_analog_on
);
// ============================================================
// State.
localparam ST_IDLE = 2'h0;
localparam ST_RUN  = 2'h1;
localparam ST_HALT = 2'h2;
reg  [1:0] state;
reg        i_busy;
reg        v_busy;
reg        i_left;
reg        cal_pending;
reg  [2:0] v_chan;
reg        v_last;
reg        v_second;
reg        restart;
reg  [1:0] ops_seen;
wire [2:0] scan_next;
wire       scan_wrap;
wire [1:0] mode = o_adc_control_a[`MODE_HI:`MODE_LO];
wire [2:0] snap = o_adc_control_a[`SNAP_HI:`SNAP_LO];
wire       pair = (snap == `SNAP_SENSE_PAIR) || (snap == `SNAP_GPIO_PAIR);
vchan_select u_sel
(
   .i_scan_sel  (o_adc_control_a[`SCAN_HI:`SCAN_LO]),
   .i_chan      (v_chan),
   .o_next_chan (scan_next),
   .o_wrap      (scan_wrap)
);
// ============================================================
// Functions.
function [2:0] first_chan;
   input [7:0] ctrl;
   begin
      if (ctrl[`MODE_HI:`MODE_LO] == `MODE_SNAPSHOT)
         first_chan = (ctrl[`SNAP_HI:`SNAP_LO] == `SNAP_SENSE_PAIR) ? `CH_SENSE_ONE :
                      (ctrl[`SNAP_HI:`SNAP_LO] == `SNAP_GPIO_PAIR) ? `CH_GPIO_ONE : ctrl[`SNAP_HI:`SNAP_LO];
      else if (ctrl[`MODE_HI:`MODE_LO] == `MODE_SCAN && ctrl[`SCAN_HI])
         first_chan = `CH_GPIO_ONE;
      else
         first_chan = `CH_SENSE_ONE;
   end
endfunction
// Power operand channel: sense or gpio pair.
function pwr_chan;
   input [2:0] ch;
   input       gpio_ops;
   begin
      pwr_chan = gpio_ops ? (ch == `CH_GPIO_ONE || ch == 3'h3) : (ch == `CH_SENSE_ONE || ch == `CH_SENSE_TWO);
   end
endfunction
wire gpio_ops = (mode == `MODE_SNAPSHOT) ? (snap == `SNAP_GPIO_PAIR) :
                (mode == `MODE_SCAN) ? o_adc_control_a[`SCAN_HI] : 1'b0;
wire v_done_last = (mode == `MODE_SCAN) ? 1'b0 :
                   (mode == `MODE_SNAPSHOT) ? (!pair || v_second) : (v_chan == `CH_GPIO_FOUR);
wire [2:0] next_v_chan = (mode == `MODE_SCAN) ? scan_next : v_chan + 3'h1;
// ============================================================
// Sequencer.
always @(posedge i_clk_sys)
begin
   if (i_rst)
   begin
      o_adc_control_a  <= `CONTROL_A_RESET;
      state            <= ST_IDLE;
      i_busy           <= 1'b0;
      v_busy           <= 1'b0;
      i_left           <= 1'b0;
      cal_pending      <= 1'b0;
      v_chan           <= 3'h0;
      v_last           <= 1'b0;
      v_second         <= 1'b0;
      restart          <= 1'b1;
      ops_seen         <= 2'h0;
      o_iconv_start    <= 1'b0;
      o_iconv_cal      <= 1'b0;
      o_vconv_start    <= 1'b0;
      o_vconv_chan     <= 3'h0;
      o_power_update   <= 1'b0;
      o_current_update <= 1'b0;
      o_voltage_update <= 1'b0;
      o_voltage_chan   <= 3'h0;
      o_status_set     <= 10'h000;
      o_alert          <= 1'b0;
      o_analog_on      <= 1'b0;
   end
   else if (i_ce)
   begin
      o_iconv_start    <= 1'b0;
      o_vconv_start    <= 1'b0;
      o_power_update   <= 1'b0;
      o_current_update <= 1'b0;
      o_voltage_update <= 1'b0;
      o_status_set     <= 10'h000;
      o_alert          <= 1'b0;
      if (i_ctrl_wr)
      begin
         o_adc_control_a <= i_ctrl_wdata;
         restart         <= 1'b1;
         cal_pending     <= 1'b1;
         i_busy          <= 1'b0;
         v_busy          <= 1'b0;
         state           <= ST_IDLE;
      end
      else if (restart)
      begin
         restart     <= 1'b0;
         o_analog_on <= (mode != `MODE_SHUTDOWN);
         if (mode == `MODE_SHUTDOWN)
            state <= ST_HALT;
         else
         begin
            state         <= ST_RUN;
            v_chan        <= first_chan(o_adc_control_a);
            o_vconv_chan  <= first_chan(o_adc_control_a);
            v_second      <= 1'b0;
            v_last        <= 1'b0;
            ops_seen      <= 2'h0;
            i_busy        <= 1'b1;
            v_busy        <= 1'b1;
            i_left        <= (mode == `MODE_SCAN);
            o_iconv_start <= 1'b1;
            o_vconv_start <= 1'b1;
            o_iconv_cal   <= !o_adc_control_a[`CAL_DEMAND_BIT] || cal_pending;
            cal_pending   <= 1'b0;
         end
      end
      else if (state == ST_RUN)
      begin
         if (i_busy && i_iconv_done)
         begin
            if (!i_bus_busy)
            begin
               o_current_update <= 1'b1;
               o_status_set[`STAT_I1] <= 1'b1;
               o_status_set[`STAT_I2] <= 1'b1;
               if ((mode != `MODE_SNAPSHOT || pair) && (mode != `MODE_SCAN || ops_seen == 2'h3))
               begin
                  o_power_update <= 1'b1;
                  o_status_set[`STAT_PWR_ONE] <= 1'b1;
                  o_status_set[`STAT_PWR_TWO] <= 1'b1;
               end
            end
            if (i_left || (mode == `MODE_SINGLE && !v_last))
            begin
               o_iconv_start <= 1'b1;
               o_iconv_cal   <= !o_adc_control_a[`CAL_DEMAND_BIT];
            end
            else
               i_busy <= 1'b0;
         end
         if (v_busy && i_vconv_done)
         begin
            if (pwr_chan(v_chan, gpio_ops))
               ops_seen[v_chan[0]] <= 1'b1;
            if (!i_bus_busy)
            begin
               o_voltage_update <= 1'b1;
               o_voltage_chan   <= v_chan;
               o_status_set[`STAT_V_LO + v_chan] <= 1'b1;
            end
            if (v_done_last)
            begin
               v_busy <= 1'b0;
               v_last <= 1'b1;
            end
            else
            begin
               v_second      <= 1'b1;
               v_chan        <= next_v_chan;
               o_vconv_chan  <= next_v_chan;
               o_vconv_start <= 1'b1;
            end
         end
         if (mode != `MODE_SCAN && !v_busy && !i_busy)
         begin
            state <= ST_HALT;
            if (mode == `MODE_SNAPSHOT && (i_alert_enable_four != 2'h0))
               o_alert <= 1'b1;
         end
      end
   end
end
endmodule

// file: src/vchan_select.v
`timescale 1ns/1ps
module vchan_select
(
   input  wire [1:0] i_scan_sel,
   input  wire [2:0] i_chan,
   output reg  [2:0] o_next_chan,
   output reg        o_wrap
);
// ============================================================
// Next voltage channel in round robin for the selected scan set.
always @*
begin
   o_next_chan = i_chan + 3'h1;
   o_wrap      = 1'b0;
   case (i_scan_sel)
      2'h0:
      begin
         o_wrap = (i_chan == 3'h5);
         if (o_wrap) o_next_chan = 3'h0;
      end
      2'h1:
      begin
         o_wrap = (i_chan == 3'h1);
         if (o_wrap) o_next_chan = 3'h0;
      end
      2'h2:
      begin
         o_wrap = (i_chan == 3'h3);
         if (o_wrap) o_next_chan = 3'h2;
      end
      default:
      begin
         o_wrap = (i_chan == 3'h5);
         if (o_wrap) o_next_chan = 3'h2;
      end
   endcase
end
endmodule

// file: tb/adc_conversion_sequencer_test.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
   logic       clk, rst, wr, busy, ce;
   logic [7:0] wdata;
   logic [1:0] aen;
   wire        idone, vdone, is, cal, vs, pw, cu, vu, al, aon;
   wire  [7:0] ctrl;
   wire  [2:0] vch, vuch;
   wire  [9:0] st;
   int         fail_count, total_checks, n_is, n_cal, n_pw, n_al, n_vs, n_cu;
   logic [5:0] vmask, chmask;
   // ==========================================
   // Clock, design and converters
   initial
   begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   adc_conversion_sequencer dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_ctrl_wr(wr), .i_ctrl_wdata(wdata),
      .i_alert_enable_four(aen), .i_bus_busy(busy), .i_iconv_done(idone), .i_vconv_done(vdone),
      .o_adc_control_a(ctrl), .o_iconv_start(is), .o_iconv_cal(cal), .o_vconv_start(vs), .o_vconv_chan(vch),
      .o_power_update(pw), .o_current_update(cu), .o_voltage_update(vu), .o_voltage_chan(vuch),
      .o_status_set(st), .o_alert(al), .o_analog_on(aon));
   conv_model conv (.i_clk_sys(clk), .i_rst(rst), .i_istart(is), .i_vstart(vs), .o_idone(idone), .o_vdone(vdone));
   always @(posedge clk)
   begin
      n_is += is;
      n_cal += is && cal;
      n_pw += pw;
      n_al += al;
      n_vs += vs;
      n_cu += cu;
      vmask |= st[9:4];
      if (vs) chmask[vch] = 1'b1;
   end
   // ==========================================
   // Tasks
   task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      total_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task clr;
      {n_is, n_cal, n_pw, n_al, n_vs, n_cu} = '0;
      vmask = 0;
      chmask = 0;
   endtask
   task wr_ctrl(input logic [7:0] d);
      @(posedge clk);
      #2 wr = 1;
      wdata = d;
      @(posedge clk);
      #2 wr = 0;
      clr();
   endtask
   task go(input logic [7:0] d, input logic b);
      @(posedge clk);
      #2 busy = b;
      wr_ctrl(d);
      repeat (200) @(posedge clk);
      #2 busy = 0;
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================
   // Tests
   initial
   begin
      {rst, wr, busy, wdata, aen} = {1'b1, 10'h0, 2'h3};
      ce = 1;
      clr();
      repeat (16) @(posedge clk);
      #2 rst = 0;
      clr();
      repeat (200) @(posedge clk);
      chk("ctrl", 10'h000, {2'h0, ctrl});
      chk("scan_ch", 10'h03F, {4'h0, chmask});
      for (int s = 1; s < 4; s++)
      begin
         go(8'(8'h80 | (s << 3)), 0);
         chk("scan_sel", s == 1 ? 10'h003 : s == 2 ? 10'h00C : 10'h03C, {4'h0, chmask});
         chk("cal_once", 10'h001, 10'(n_cal));
      end
      for (int c = 0; c < 8; c++)
      begin
         go(8'(8'h20 | c), 0);
         chk("snap_is", 10'h001, 10'(n_is));
         chk("snap_cu", 10'h001, 10'(n_cu));
         chk("snap_vm", c < 6 ? 10'(1 << c) : c == 6 ? 10'h003 : 10'h00C, {4'h0, vmask});
         chk("snap_pw", 10'(c > 5), 10'(n_pw));
         chk("snap_al", 10'h001, 10'(n_al));
         chk("snap_cal", 10'h001, 10'(n_cal));
      end
      go(8'hC0, 0);
      chk("single_vm", 10'h03F, {4'h0, vmask});
      chk("single_cal", 10'h001, 10'(n_cal));
      clr();
      repeat (50) @(posedge clk);
      chk("halt", 10'h000, 10'(n_is + n_vs));
      #2 aen = 0;
      go(8'h20, 1);
      chk("busy_vm", 10'h000, {4'h0, vmask});
      chk("no_alert", 10'h000, 10'(n_al));
      aen = 3;
      wr_ctrl(8'h21);
      repeat (5) @(posedge clk);
      go(8'h22, 0);
      chk("abort_vm", 10'h004, {4'h0, vmask});
      chk("abort_is", 10'h001, 10'(n_is));
      wr_ctrl(8'h20);
      busy = 1;
      repeat (3) @(posedge clk);
      #2 busy = 0;
      repeat (100) @(posedge clk);
      chk("burst_vm", 10'h001, {4'h0, vmask});
      chk("burst_cu", 10'h001, 10'(n_cu));
      go(8'h60, 0);
      chk("analog", 10'h000, {9'h0, aon});
      chk("sd_is", 10'h000, 10'(n_is));
      #2 ce = 0;
      wr_ctrl(8'h20);
      repeat (20) @(posedge clk);
      chk("ce_hold", 10'h060, {2'h0, ctrl});
      chk("ce_is", 10'h000, 10'(n_is));
      #2 ce = 1;
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test();
   end
endmodule

// file: tb/adc_seq_monitor.sv
`timescale 1ns/1ps
module adc_seq_monitor
(
   input wire       i_clk_sys, i_rst, i_ce, i_ctrl_wr, i_bus_busy,
   input wire [7:0] i_ctrl_wdata, o_adc_control_a,
   input wire [1:0] i_alert_enable_four,
   input wire       o_iconv_start, o_iconv_cal, o_vconv_start, o_power_update,
   input wire       o_current_update, o_voltage_update, o_alert, o_analog_on,
   input wire [2:0] o_vconv_chan, o_voltage_chan,
   input wire [9:0] o_status_set
);
   wire [1:0] md = o_adc_control_a[6:5];
   wire [2:0] sn = o_adc_control_a[2:0];
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // ==========================================
   // Properties
   a_ctrl_readback: assert property (i_ce && i_ctrl_wr |=> o_adc_control_a == $past(i_ctrl_wdata))
      else $error("control readback wrong");
   a_write_restart: assert property (i_ce && i_ctrl_wr && i_ctrl_wdata[6:5] != 2'h3 ##1 i_ce && !i_ctrl_wr
      |=> o_iconv_start && o_vconv_start) else $error("no start two cycles after write");
   a_cal_every: assert property (o_iconv_start && !o_adc_control_a[7] |-> o_iconv_cal)
      else $error("current conversion without calibration");
   a_shutdown_idle: assert property (md == 2'h3 && $stable(o_adc_control_a)
      |-> !o_analog_on && !o_iconv_start && !o_vconv_start) else $error("activity in shutdown");
   a_busy_drops: assert property (i_bus_busy && $past(i_bus_busy)
      |-> !o_current_update && !o_voltage_update && !o_power_update && o_status_set == 10'h000)
      else $error("result written while bus busy");
   a_snap_no_power: assert property (md == 2'h1 && sn < 3'h6 && !$past(i_ctrl_wr) |-> !o_power_update)
      else $error("power updated by single snapshot");
   a_snap_chan: assert property (o_vconv_start && md == 2'h1 && sn < 3'h6 |-> o_vconv_chan == sn)
      else $error("snapshot channel wrong");
   a_scan_sense: assert property (o_vconv_start && md == 2'h0 && o_adc_control_a[4:3] == 2'h1
      |-> o_vconv_chan < 3'h2) else $error("scan left sense inputs");
   a_alert_cause: assert property (o_alert |-> md == 2'h1 && i_alert_enable_four != 2'h0)
      else $error("alert without enabled snapshot");
   a_volt_status: assert property (o_voltage_update |-> ((o_status_set >> o_voltage_chan) & 10'h010) != 0)
      else $error("voltage new-data bit missing");
   c_snap_alert: cover property (o_alert);
   c_snap_power: cover property (o_power_update && md == 2'h1);
   c_shutdown: cover property (!o_analog_on && md == 2'h3);
endmodule
bind adc_conversion_sequencer adc_seq_monitor u_mon (.*);

// file: tb/conv_model.sv
`timescale 1ns/1ps
module conv_model
#(
   parameter int I_LAT = 20,
   parameter int V_LAT = 9
)
(
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   input  wire logic i_istart,
   input  wire logic i_vstart,
   output logic      o_idone,
   output logic      o_vdone
);
   int icnt;
   int vcnt;
   // ==========================================
   // Converters answer each start with one done strobe; a new start drops the old one.
   always @(posedge i_clk_sys)
   begin
      o_idone <= !i_rst && !i_istart && icnt == 1;
      o_vdone <= !i_rst && !i_vstart && vcnt == 1;
      icnt <= i_rst ? 0 : i_istart ? I_LAT : icnt > 0 ? icnt - 1 : 0;
      vcnt <= i_rst ? 0 : i_vstart ? V_LAT : vcnt > 0 ? vcnt - 1 : 0;
   end
endmodule
